// [pkg/flash_guard_pkg.sv]
// constants, command codes and carriers of the sector protection block
package flash_guard_pkg;

  // ****************************************************************
  // array geometry and clock
  // ****************************************************************
  localparam int SECTOR_COUNT = 16;              // sectors in the main array
  localparam int SECT_W       = 4;               // sector index width
  localparam int CLK_MHZ      = 20;              // CLK rate
  localparam int TIMER_W      = 24;              // busy timer width

  // ****************************************************************
  // timing: figures in their own unit, cycles derived from CLK_MHZ
  // ****************************************************************
  localparam int PW_WINDOW_US     = 100;         // least unlock spacing
  localparam int PW_WINDOW_CYC    = PW_WINDOW_US * CLK_MHZ;
  localparam int PAGE_PROG_US     = 250;         // typical page program
  localparam int PAGE_PROG_CYC    = PAGE_PROG_US * CLK_MHZ;
  localparam int SECTOR_ERASE_MS  = 500;         // typical sector erase
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_MS * 1000 * CLK_MHZ;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CMD    = 8'h00;     // command issue, write only
  localparam logic [7:0] OFF_STATUS = 8'h04;     // status, read only
  localparam logic [7:0] OFF_PW_LO  = 8'h08;     // supplied password low
  localparam logic [7:0] OFF_PW_HI  = 8'h0C;     // supplied password high
  localparam logic [7:0] OFF_CFG    = 8'h10;     // status/config register
  localparam logic [7:0] OFF_PSB    = 8'h14;     // persistent bits, read only
  localparam logic [7:0] OFF_DYN    = 8'h18;     // dynamic bits, read only

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CMD_OP_LSB   = 0;               // op code [3:0]
  localparam int CMD_SECT_LSB = 8;               // sector [11:8]
  localparam int CMD_VAL_BIT  = 16;              // dynamic bit value
  localparam int CMD_GRD_LSB  = 17;              // guard-mode bits [18:17]
  localparam int ST_WIP_BIT   = 0;
  localparam int ST_ERR_BIT   = 1;
  localparam int ST_LOCK_BIT  = 2;
  localparam int ST_PSBRD_BIT = 3;
  localparam int ST_DONE_BIT  = 4;
  localparam int ST_GRD_LSB   = 5;               // guard-mode bits [6:5]
  localparam int CFG_SWD_BIT  = 0;               // status_write_disable
  localparam int CFG_BG_LSB   = 1;               // block_guard_bits [3:1]

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [1:0]  GUARD_RST = 2'h3;      // no mode chosen
  localparam logic [63:0] PW_RST    = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [3:0]  CFG_RST   = 4'h0;
  localparam logic [1:0]  GUARD_PERSIST  = 2'h2;
  localparam logic [1:0]  GUARD_PASSWORD = 2'h1;
  localparam logic [1:0]  GUARD_ILLEGAL  = 2'h0;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [3:0] OP_PSB_PROG   = 4'h1;
  localparam logic [3:0] OP_PSB_ERASE  = 4'h2;
  localparam logic [3:0] OP_PSB_READ   = 4'h3;
  localparam logic [3:0] OP_DYN_WRITE  = 4'h4;
  localparam logic [3:0] OP_LOCK_CLEAR = 4'h5;   // lock_clear_command
  localparam logic [3:0] OP_PW_UNLOCK  = 4'h6;
  localparam logic [3:0] OP_GUARD_PROG = 4'h7;
  localparam logic [3:0] OP_PW_PROG    = 4'h8;
  localparam logic [3:0] OP_MAIN_PROG  = 4'h9;
  localparam logic [3:0] OP_MAIN_ERASE = 4'hA;
  localparam logic [3:0] OP_CLR_STATUS = 4'hB;
  localparam logic [3:0] OP_SOFT_RESET = 4'hC;

  // one command as written to OFF_CMD
  typedef struct packed {
    logic [3:0]        op;
    logic [SECT_W-1:0] sector;
    logic              value;
    logic [1:0]        guard;
  } cmd_s;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_BUSY, ST_PREPROG, ST_ERASE, ST_VERIFY, ST_FAIL
  } seq_e;

endpackage

// [hw/flash_guard.sv]
// sector write and erase protection logic behind an AHB-Lite slave
//
// What this block does
// - low WP with disable bit freezes config
// - sector protected if block or sector guard
// - persistent or dynamic bit zero protects sector
// - lock zero protects all persistent bits
// - persistent mode: reset sets lock to one
// - persistent mode: command clears lock, never sets
// - password mode: hardware reset clears lock to zero
// - matching 64-bit password sets lock
// - password mode: command clears lock
// - guard bits 11 default, 10 persistent, 01 password
// - programming guard bits 00 fails
// - chosen mode blocks further guard programming
// - delivered state: persistent mode, all unprotected
// - write in progress while guard programs
// - persistent bits programmed singly, erased together
// - lock zero makes persistent program/erase fail
// - persistent bit erase preprograms and verifies internally
// - progress shown in status during program/erase
// - persistent bit readable per sector
// - dynamic bit write clears or sets freely
// - dynamic bit counts only where persistent one
// - software reset leaves lock unchanged
// - resets return dynamic bits to unprotected
// - password mismatch sets error, wip stays
// - unlock attempts spaced by 100 us
`timescale 1ns/10ps
`default_nettype none

module flash_guard
  import flash_guard_pkg::*;
#(
  parameter int PROG_CYC  = PAGE_PROG_CYC,     // page program busy time
  parameter int ERASE_CYC = SECTOR_ERASE_CYC   // sector erase busy time
) (
  input  wire logic        CLK,                // system clock
  input  wire logic        RST_N,              // power-on reset
  input  wire logic        HWRST_N,            // hardware reset pin
  input  wire logic        WP_N,               // write-protect pin
  input  wire logic        HSEL,               // slave select
  input  wire logic [31:0] HADDR,              // byte address
  input  wire logic [1:0]  HTRANS,             // transfer type
  input  wire logic        HWRITE,             // write when high
  input  wire logic [2:0]  HSIZE,              // transfer size
  input  wire logic [31:0] HWDATA,             // write data
  input  wire logic        HREADY,             // bus ready
  output logic      [31:0] HRDATA,             // read data
  output logic             HREADYOUT,          // slave ready
  output logic             HRESP,              // always OKAY
  output logic             WRITE_IN_PROGRESS                 // write in progress
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] wp_sync_reg;
  logic [1:0] hw_sync_reg;

  // two stages each; only the second stage is read by logic
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wp_sync_reg <= 2'h3;
      hw_sync_reg <= 2'h3;
    end else begin
      wp_sync_reg <= {wp_sync_reg[0], WP_N};
      hw_sync_reg <= {hw_sync_reg[0], HWRST_N};
    end
  end

  wire wp_low    = ~wp_sync_reg[1];
  wire hw_active = ~hw_sync_reg[1];

  // ****************************************************************
  // AHB-Lite address and data phase
  // ****************************************************************
  logic       dp_wr_reg;
  logic [7:0] dp_addr_reg;
  logic [31:0] hrdata_reg;

  wire ap_sel   = HSEL & HTRANS[1] & HREADY;
  wire ap_write = ap_sel & HWRITE;
  wire ap_read  = ap_sel & ~HWRITE;
  wire word_ok  = (HSIZE == 3'h2) & (HADDR[31:8] == 24'h000000);

  // write decode happens in the data phase, when HWDATA stands
  wire wr_cmd   = dp_wr_reg & (dp_addr_reg == OFF_CMD);
  wire wr_pw_lo = dp_wr_reg & (dp_addr_reg == OFF_PW_LO);
  wire wr_pw_hi = dp_wr_reg & (dp_addr_reg == OFF_PW_HI);
  wire wr_cfg   = dp_wr_reg & (dp_addr_reg == OFF_CFG);

  // ****************************************************************
  // protection state
  // ****************************************************************
  seq_e                    state_reg,    state_next;
  logic [TIMER_W-1:0]      timer_reg,    timer_next;
  cmd_s                    pend_reg,     pend_next;
  logic [SECTOR_COUNT-1:0] psb_reg,      psb_next;
  logic [SECTOR_COUNT-1:0] dyn_reg,      dyn_next;
  logic                    lock_reg,     lock_next;
  logic                    err_reg,      err_next;
  logic                    psbrd_reg,    psbrd_next;
  logic                    done_reg,     done_next;
  logic [1:0]              guard_reg,    guard_next;
  logic [63:0]             pw_reg,       pw_next;
  logic [63:0]             pw_in_reg,    pw_in_next;
  logic [3:0]              cfg_reg,      cfg_next;

  wire cmd_s cmd = '{op:     HWDATA[CMD_OP_LSB +: 4],
                     sector: HWDATA[CMD_SECT_LSB +: SECT_W],
                     value:  HWDATA[CMD_VAL_BIT],
                     guard:  HWDATA[CMD_GRD_LSB +: 2]};

  wire       swd     = cfg_reg[CFG_SWD_BIT];
  wire [2:0] bg      = cfg_reg[CFG_BG_LSB +: 3];
  wire       pw_mode = (guard_reg == GUARD_PASSWORD);
  wire       unset   = (guard_reg == GUARD_RST);
  wire       cfg_frozen = wp_low & swd;

  // block guard protects the top 1,2,4.. sectors; code 7 protects all
  wire [5:0] bg_span = (bg == 3'h0) ? 6'h00 :
                       (bg == 3'h7) ? 6'(SECTOR_COUNT) :
                       (6'h01 << (bg - 3'h1));
  logic [SECTOR_COUNT-1:0] prot_vec;

  // per-sector combined protection
  for (genvar s = 0; s < SECTOR_COUNT; s++) begin : g_prot
    wire bg_hit = 6'(SECTOR_COUNT - 1 - s) < bg_span;
    // dynamic bit only matters where the persistent bit is one
    wire guard_hit = ~psb_reg[s] | (psb_reg[s] & ~dyn_reg[s]);
    assign prot_vec[s] = bg_hit | guard_hit;
  end

  wire sect_prot = prot_vec[cmd.sector];
  wire pw_match  = (pw_in_reg == pw_reg);
  wire tmr_end   = (timer_reg == TIMER_W'(1));

  // ****************************************************************
  // command sequencer, next-state logic
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    timer_next = (timer_reg != '0) ? timer_reg - TIMER_W'(1) : timer_reg;
    pend_next  = pend_reg;
    psb_next   = psb_reg;
    dyn_next   = dyn_reg;
    lock_next  = lock_reg;
    err_next   = err_reg;
    psbrd_next = psbrd_reg;
    done_next  = done_reg;
    guard_next = guard_reg;
    pw_next    = pw_reg;
    pw_in_next = pw_in_reg;
    cfg_next   = cfg_reg;
    if (wr_pw_lo)
      pw_in_next[31:0] = HWDATA;
    if (wr_pw_hi)
      pw_in_next[63:32] = HWDATA;
    // config writes refused while the write-protect pin guards them
    if (wr_cfg && !cfg_frozen)
      cfg_next = HWDATA[3:0];
    case (state_reg)
      ST_IDLE: begin
        if (wr_cmd) begin
          pend_next = cmd;
          done_next = 1'b0;
          case (cmd.op)
            OP_PSB_PROG: begin
              if (!lock_reg) begin
                state_next = ST_FAIL;
                err_next   = 1'b1;
              end else begin
                state_next = ST_BUSY;
                timer_next = TIMER_W'(PROG_CYC);
              end
            end
            OP_PSB_ERASE: begin
              if (!lock_reg) begin
                state_next = ST_FAIL;
                err_next   = 1'b1;
              end else begin
                state_next = ST_PREPROG;
                timer_next = TIMER_W'(PROG_CYC);
              end
            end
            OP_PSB_READ:
              psbrd_next = psb_reg[cmd.sector];
            OP_DYN_WRITE:
              dyn_next[cmd.sector] = cmd.value;
            OP_LOCK_CLEAR:
              lock_next = 1'b0;
            OP_PW_UNLOCK: begin
              if (pw_mode && pw_match) begin
                lock_next = 1'b1;
              end else if (pw_mode) begin
                // a wrong guess holds wip for the whole window
                state_next = ST_BUSY;
                timer_next = TIMER_W'(PW_WINDOW_CYC);
              end
            end
            OP_GUARD_PROG: begin
              if (!unset || cmd.guard == GUARD_ILLEGAL) begin
                state_next = ST_FAIL;
                err_next   = 1'b1;
              end else if (cmd.guard != GUARD_RST) begin
                state_next = ST_BUSY;
                timer_next = TIMER_W'(PROG_CYC);
              end
            end
            OP_PW_PROG: begin
              // ignored once a mode is chosen; hides the password
              if (unset) begin
                state_next = ST_BUSY;
                timer_next = TIMER_W'(PROG_CYC);
              end
            end
            OP_MAIN_PROG, OP_MAIN_ERASE: begin
              if (sect_prot) begin
                state_next = ST_FAIL;
                err_next   = 1'b1;
              end else begin
                state_next = ST_BUSY;
                timer_next = (cmd.op == OP_MAIN_PROG) ?
                             TIMER_W'(PROG_CYC) : TIMER_W'(ERASE_CYC);
              end
            end
            OP_CLR_STATUS:
              err_next = 1'b0;
            OP_SOFT_RESET: begin
              dyn_next = '1;
              err_next = 1'b0;                          // lock kept
            end
            default: ;
          endcase
        end
      end
      ST_BUSY: begin
        if (tmr_end) begin
          state_next = ST_IDLE;
          case (pend_reg.op)
            OP_PSB_PROG:
              psb_next[pend_reg.sector] = 1'b0;
            OP_GUARD_PROG:
              guard_next = guard_reg & pend_reg.guard;
            OP_PW_PROG:
              pw_next = pw_reg & pw_in_reg;             // zeros only
            OP_PW_UNLOCK: begin
              state_next = ST_FAIL;
              err_next   = 1'b1;
            end
            default:
              done_next = 1'b1;
          endcase
        end
      end
      ST_PREPROG: begin
        if (tmr_end) begin
          psb_next   = '0;
          state_next = ST_ERASE;
          timer_next = TIMER_W'(ERASE_CYC);
        end
      end
      ST_ERASE: begin
        if (tmr_end) begin
          psb_next   = '1;
          state_next = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        // a failed verify leaves the error standing
        if (&psb_reg) begin
          state_next = ST_IDLE;
          done_next  = 1'b1;
        end else begin
          state_next = ST_FAIL;
          err_next   = 1'b1;
        end
      end
      ST_FAIL: begin
        // wip stays up until software or the hardware reset pin clears the error
        if (wr_cmd && (cmd.op == OP_CLR_STATUS ||
                       cmd.op == OP_SOFT_RESET)) begin
          state_next = ST_IDLE;
          err_next   = 1'b0;
          if (cmd.op == OP_SOFT_RESET)
            dyn_next = '1;
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
    // hardware reset pin: volatile state back to its mode default
    if (hw_active) begin
      state_next = ST_IDLE;
      timer_next = '0;
      dyn_next   = '1;
      err_next   = 1'b0;
      lock_next  = ~pw_mode;
    end
  end

  // ****************************************************************
  // state registers; power-on gives the delivered state
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      pend_reg  <= '0;
      psb_reg   <= '1;
      dyn_reg   <= '1;
      lock_reg  <= 1'b1;
      err_reg   <= 1'b0;
      psbrd_reg <= 1'b0;
      done_reg  <= 1'b0;
      guard_reg <= GUARD_RST;
      pw_reg    <= PW_RST;
      pw_in_reg <= '0;
      cfg_reg   <= CFG_RST;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      pend_reg  <= pend_next;
      psb_reg   <= psb_next;
      dyn_reg   <= dyn_next;
      lock_reg  <= lock_next;
      err_reg   <= err_next;
      psbrd_reg <= psbrd_next;
      done_reg  <= done_next;
      guard_reg <= guard_next;
      pw_reg    <= pw_next;
      pw_in_reg <= pw_in_next;
      cfg_reg   <= cfg_next;
    end
  end

  // ****************************************************************
  // read mux and bus outputs
  // ****************************************************************
  wire wip_now = (state_reg != ST_IDLE);
  wire [31:0] status_word = {25'h0000000, guard_reg, done_reg, psbrd_reg,
                             lock_reg, err_reg, wip_now};
  wire [7:0] ra = HADDR[7:0];
  // password registers read back as zero so the secret never leaks
  wire [31:0] rd_mux =
    (!word_ok)          ? 32'h00000000 :
    (ra == OFF_STATUS)  ? status_word :
    (ra == OFF_CFG)     ? {28'h0000000, cfg_reg} :
    (ra == OFF_PSB)     ? {16'h0000, psb_reg} :
    (ra == OFF_DYN)     ? {16'h0000, dyn_reg} : 32'h00000000;

  // zero wait states: read data sampled at the address phase edge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h00000000;
      WRITE_IN_PROGRESS         <= 1'b0;
    end else begin
      dp_wr_reg   <= ap_write & word_ok;
      dp_addr_reg <= HADDR[7:0];
      hrdata_reg  <= ap_read ? rd_mux : hrdata_reg;
      WRITE_IN_PROGRESS         <= (state_next != ST_IDLE);
    end
  end

  // ready and response never change: every access is OKAY
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  assign HRDATA = hrdata_reg;

endmodule

`default_nettype wire

// [sim/flash_guard_monitor.sv]
// port checker for the sector protection block
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// checker
// ****************************************
module flash_guard_monitor
  import flash_guard_pkg::*;
(
  input wire logic        CLK,       // clock
  input wire logic        RST_N,     // reset
  input wire logic        HWRST_N,   // hardware reset
  input wire logic        HSEL,      // select
  input wire logic [31:0] HADDR,     // address
  input wire logic [1:0]  HTRANS,    // transfer type
  input wire logic        HWRITE,    // direction
  input wire logic [31:0] HWDATA,    // write data
  input wire logic        HREADY,    // bus ready
  input wire logic [31:0] HRDATA,    // read data
  input wire logic        HREADYOUT, // slave ready
  input wire logic        HRESP,     // response
  input wire logic        WRITE_IN_PROGRESS        // busy
);
  // address phase decode; cmd_dp marks a command write's data phase
  wire logic       a_ph = HSEL & HTRANS[1] & HREADY;
  wire logic [3:0] op   = HWDATA[3:0];
  logic            cmd_dp;
  always_ff @(posedge CLK) begin
    cmd_dp <= RST_N & a_ph & HWRITE & (HADDR[7:0] == OFF_CMD);
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_ready_high: assert property (HREADYOUT)
    else $error("slave stalled the bus");
  a_resp_okay: assert property (!HRESP)
    else $error("slave gave an error response");
  a_pw_hidden: assert property (
    a_ph && !HWRITE && HADDR[7:3] == 5'h01 |=> HRDATA == 32'h0)
    else $error("supplied password readable");
  a_psb_busy: assert property (
    cmd_dp && op == OP_PSB_PROG && !WRITE_IN_PROGRESS |-> ##[1:3] WRITE_IN_PROGRESS)
    else $error("persistent bit program not busy");
  a_guard_busy: assert property (
    cmd_dp && op == OP_GUARD_PROG && HWDATA[18:17] != GUARD_RST
    && !WRITE_IN_PROGRESS |-> ##[1:3] WRITE_IN_PROGRESS)
    else $error("guard program not busy");
  a_dyn_quick: assert property (
    cmd_dp && op == OP_DYN_WRITE && !WRITE_IN_PROGRESS |=> !WRITE_IN_PROGRESS [*3])
    else $error("dynamic bit write went busy");
  a_hwrst_idle: assert property (!HWRST_N [*5] |=> !WRITE_IN_PROGRESS)
    else $error("busy kept through hardware reset");
  a_soft_idle: assert property (
    cmd_dp && op == OP_SOFT_RESET |-> ##[1:3] !WRITE_IN_PROGRESS)
    else $error("soft reset left block busy");

  c_unlock: cover property (cmd_dp && op == OP_PW_UNLOCK);
  c_erase: cover property (cmd_dp && op == OP_PSB_ERASE);
  c_hwrst: cover property (!HWRST_N [*5]);
endmodule
`default_nettype wire

// [sim/flash_host.sv]
// bus master model of the host issuing protection commands
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// host model
// ****************************************
module flash_host (
  input  wire logic        CLK,    // clock
  input  wire logic        HREADY, // slave ready
  input  wire logic [31:0] HRDATA, // read data
  output logic             HSEL,   // select
  output logic [31:0]      HADDR,  // address
  output logic [1:0]       HTRANS, // transfer type
  output logic             HWRITE, // direction
  output logic [2:0]       HSIZE,  // always a word
  output logic [31:0]      HWDATA  // write data
);
  // idle bus at time zero
  initial begin
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
  end

  // one word transfer; released data line toggles so stale data never pass
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= w ? d : ~HWDATA;
    do @(posedge CLK); while (HREADY !== 1'b1);
    q = HRDATA;
    HWDATA <= ~HWDATA;
  endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the sector protection block
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// bench
// ****************************************
module tb_top
  import flash_guard_pkg::*;
;
  logic        clk, rst_n, hwrst_n, wp_n;
  logic        hsel, hwrite, hreadyout, hresp, write_in_progress;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          num_errors, comparisons;
  time         t0;
  localparam logic [31:0] PWL = 32'h0F0F1234; // arbitrary password

  flash_guard #(.PROG_CYC(20), .ERASE_CYC(40)) DUT (
    .CLK(clk), .RST_N(rst_n), .HWRST_N(hwrst_n), .WP_N(wp_n),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .WRITE_IN_PROGRESS(write_in_progress));
  flash_host host (
    .CLK(clk), .HREADY(hreadyout), .HRDATA(hrdata), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic ckst(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, OFF_STATUS, 32'h0, q);
    chk(q & m, e);
  endtask
  // issue a command, then poll until idle or failed; host never
  // stacks commands on a busy block
  task automatic go(input logic [3:0] o, input logic [3:0] s = 4'h0,
                    input logic v = 1'b0, input logic [1:0] g = 2'h3);
    logic [31:0] q;
    wr(OFF_CMD, {13'h0, g, v, 4'h0, s, 4'h0, o});
    for (int i = 0; i < 3000; i++) begin
      host.xfer(1'b0, OFF_STATUS, 32'h0, q);
      if (q[1:0] !== 2'b01) break;
    end
    // a command that never settles counts against the run
    if (q[1:0] === 2'b01) begin
      num_errors++;
      $display("wrong value at %0t: command still busy", $time);
    end
  endtask
  task automatic hw_reset;
    hwrst_n <= 1'b0;
    repeat (6) @(posedge clk);
    hwrst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // watchdog: the sequence needs well under 40000 cycles
  initial begin
    #2000000;
    num_errors++;
    report_and_stop;
  end

  initial begin
    rst_n = 1'b0;
    hwrst_n = 1'b1;
    wp_n = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    ckst(32'h77, 32'h64);
    ck(OFF_PSB, 32'hFFFF);
    ck(OFF_DYN, 32'hFFFF);
    ck(8'h1C, 32'h0);
    ck(OFF_PW_LO, 32'h0);
    go(OP_DYN_WRITE, 4'h3, 1'b0);
    ck(OFF_DYN, 32'hFFF7);
    go(OP_MAIN_PROG, 4'h3);
    ckst(32'h3, 32'h3);
    go(OP_CLR_STATUS);
    go(OP_DYN_WRITE, 4'h3, 1'b1);
    go(OP_MAIN_PROG, 4'h3);
    ckst(32'h13, 32'h10);
    go(OP_PSB_PROG, 4'h5);
    ck(OFF_PSB, 32'hFFDF);
    go(OP_PSB_READ, 4'h5);
    ckst(32'h8, 32'h0);
    go(OP_PSB_READ, 4'h4);
    ckst(32'h8, 32'h8);
    go(OP_MAIN_ERASE, 4'h5);
    ckst(32'h3, 32'h3);
    go(OP_CLR_STATUS);
    go(OP_MAIN_ERASE, 4'h4);
    ckst(32'h13, 32'h10);
    wr(OFF_CFG, 32'h2);
    go(OP_MAIN_PROG, 4'hF);
    ckst(32'h3, 32'h3);
    go(OP_CLR_STATUS);
    wr(OFF_CFG, 32'h1);
    wp_n <= 1'b0;
    repeat (3) @(posedge clk);
    wr(OFF_CFG, 32'h0);
    ck(OFF_CFG, 32'h1);
    wp_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr(OFF_CFG, 32'h0);
    ck(OFF_CFG, 32'h0);
    go(OP_PSB_ERASE);
    ck(OFF_PSB, 32'hFFFF);
    ckst(32'h13, 32'h10);
    go(OP_DYN_WRITE, 4'h0, 1'b0);
    go(OP_LOCK_CLEAR);
    ckst(32'h4, 32'h0);
    go(OP_PSB_PROG, 4'h2);
    ckst(32'h3, 32'h3);
    go(OP_CLR_STATUS);
    ck(OFF_PSB, 32'hFFFF);
    go(OP_SOFT_RESET);
    ckst(32'h4, 32'h0);
    ck(OFF_DYN, 32'hFFFF);
    hw_reset;
    ckst(32'h4, 32'h4);
    go(OP_GUARD_PROG, 4'h0, 1'b0, 2'h0);
    ckst(32'h3, 32'h3);
    go(OP_CLR_STATUS);
    wr(OFF_PW_LO, PWL);
    wr(OFF_PW_HI, ~PWL);
    go(OP_PW_PROG);
    go(OP_GUARD_PROG, 4'h0, 1'b0, 2'h1);
    ckst(32'h63, 32'h20);
    go(OP_GUARD_PROG, 4'h0, 1'b0, 2'h2);
    ckst(32'h3, 32'h3);
    go(OP_CLR_STATUS);
    ckst(32'h60, 32'h20);
    hw_reset;
    ckst(32'h4, 32'h0);
    wr(OFF_PW_LO, PWL ^ 32'h1);
    t0 = $time;
    go(OP_PW_UNLOCK);
    chk({31'h0, ($time - t0) >= PW_WINDOW_US * 1000}, 32'h1);
    ckst(32'h7, 32'h3);
    go(OP_CLR_STATUS);
    wr(OFF_PW_LO, PWL);
    go(OP_PW_UNLOCK);
    ckst(32'h7, 32'h4);
    go(OP_LOCK_CLEAR);
    ckst(32'h4, 32'h0);
    report_and_stop;
  end
endmodule

bind flash_guard flash_guard_monitor mon (
  .CLK(CLK), .RST_N(RST_N), .HWRST_N(HWRST_N), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS));
`default_nettype wire
